// file: common/ahpc_map.vh
// Constants for the converter host port control block
`ifndef AHPC_MAP_VH
`define AHPC_MAP_VH

`define AHPC_DATA_W         10
`define AHPC_STRB_W         3
`define AHPC_STRB_IDLE      3'h7
`define AHPC_CTRL_RESET     10'h000
`define AHPC_STATUS_MODE    9
`define AHPC_SIMUL_BIT      6
`define AHPC_CHAN_LSB       0
`define AHPC_CHAN_MSB       2
`define AHPC_CHAN_W         3
`define AHPC_CONV_CYCLES    8'h13
`define AHPC_CNT_W          8
`define AHPC_CNT_ZERO       8'h00
`define AHPC_CNT_ONE        8'h01

`endif

// file: hw/ahpc_sync2.v
// Two-stage synchroniser for a vector of pin inputs
module ahpc_sync2 #(
	parameter         W       = 1,
	parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
	// Clock and reset
	input  wire         sys_clk_in,
	input  wire         reset_in,
	// Data
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;
	genvar i;

	// Per-bit two flip-flop chain; reset value is a constant per instance
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge sys_clk_in or posedge reset_in) begin
				if (reset_in) begin
					meta_q[i] <= RST_VAL[i];
					sync_q[i] <= RST_VAL[i];
				end else begin
					meta_q[i] <= async_in[i];
					sync_q[i] <= meta_q[i];
				end
			end
		end
	endgenerate

	assign sync_out = sync_q;
endmodule // ahpc_sync2

// file: hw/ahpc_port_ctrl.v
// Host port, control register and conversion status of the converter
// Contract
// R1 - Read and write strobes are obeyed only while chip select is low.
// R2 - The data bus carries results to the host on reads and control words from it on writes.
// R3 - The control register captures the bus word at the rising edge of the write strobe.
// R4 - Each write strobe rising edge starts acquisition and conversion with no further action.
// R5 - The status output is active low, busy-like when the mode bit is 0, interrupt-like when 1.
// R6 - In busy mode status is low from conversion start until the (pair of) conversion(s) ends.
// R7 - In interrupt mode status goes low once the conversion or pair completes and stays low.
// R8 - In interrupt mode a falling write or read strobe returns status high.
// R9 - With chip select low the read strobe enables the bus drivers with the stored result.
// R10 - The control register is ten bits, write-only and cleared to zero at reset.
// R11 - The low three control bits hold the channel address.
// R12 - Bus drivers stay off unless a selected read is in progress.
`include "ahpc_map.vh"

module ahpc_port_ctrl (
	// Clock and reset
	input  wire                     sys_clk_in,
	input  wire                     reset_in,
	// Host strobes (pins, active low)
	input  wire                     chip_sel_n_in,
	input  wire                     write_n_in,
	input  wire                     read_n_in,
	// Host data bus, split into three signals
	input  wire [`AHPC_DATA_W-1:0]  host_data_bus_in,
	output wire [`AHPC_DATA_W-1:0]  host_data_bus_out,
	output wire                     host_data_bus_oe_out,
	// Converter core
	input  wire                     conv_done_in,
	input  wire [`AHPC_DATA_W-1:0]  conv_result_in,
	output wire                     conv_start_out,
	output wire [`AHPC_CHAN_W-1:0]  channel_address_field_out,
	output wire                     simul_sample_out,
	output wire [`AHPC_DATA_W-1:0]  ctrl_word_out,
	// Status pin (active low)
	output wire                     status_n_out
);
	// ---------------------------------------------------------------
	// Pin synchronisation
	// ---------------------------------------------------------------
	wire [`AHPC_STRB_W-1:0] strb_s;
	wire [`AHPC_DATA_W-1:0] data_s;
	wire                    cs_n_s;
	wire                    wr_n_s;
	wire                    rd_n_s;

	// Strobes reset to their idle (high) level so no false edge follows reset
	ahpc_sync2 #(
		.W       (`AHPC_STRB_W),
		.RST_VAL (`AHPC_STRB_IDLE)
	) u_strb_sync (
		.sys_clk_in (sys_clk_in),
		.reset_in   (reset_in),
		.async_in   ({chip_sel_n_in, write_n_in, read_n_in}),
		.sync_out   (strb_s)
	);

	ahpc_sync2 #(
		.W       (`AHPC_DATA_W),
		.RST_VAL (`AHPC_CTRL_RESET)
	) u_data_sync (
		.sys_clk_in (sys_clk_in),
		.reset_in   (reset_in),
		.async_in   (host_data_bus_in),
		.sync_out   (data_s)
	);

	assign cs_n_s = strb_s[2];
	assign wr_n_s = strb_s[1];
	assign rd_n_s = strb_s[0];

	// ---------------------------------------------------------------
	// Strobe edge detection
	// ---------------------------------------------------------------
	reg  wr_n_q;
	reg  rd_n_q;
	reg  data_q;
	wire sel_w;
	wire wr_rise;
	wire wr_fall;
	wire rd_fall;

	// Previous strobe levels, taken after the synchroniser only
	always @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			wr_n_q <= 1'b1;
			rd_n_q <= 1'b1;
		end else begin
			wr_n_q <= wr_n_s;
			rd_n_q <= rd_n_s;
		end
	end

	// R1 select gates strobes
	assign sel_w   = ~cs_n_s;
	assign wr_rise = sel_w & ~wr_n_q & wr_n_s;
	assign wr_fall = sel_w & wr_n_q & ~wr_n_s;
	assign rd_fall = sel_w & rd_n_q & ~rd_n_s;

	// ---------------------------------------------------------------
	// Control register
	// ---------------------------------------------------------------
	reg [`AHPC_DATA_W-1:0] ctrl_q;

	// R3 latch on rise; R10 cleared at reset
	// Data passes the same two stages as the strobes, so it stays aligned
	always @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in)
			ctrl_q <= `AHPC_CTRL_RESET;
		else if (wr_rise)
			ctrl_q <= data_s;
	end

	// R11 channel address field
	assign channel_address_field_out = ctrl_q[`AHPC_CHAN_MSB:`AHPC_CHAN_LSB];
	assign simul_sample_out          = ctrl_q[`AHPC_SIMUL_BIT];
	assign ctrl_word_out             = ctrl_q;

	// ---------------------------------------------------------------
	// Conversion sequencer
	// ---------------------------------------------------------------
	localparam ST_IDLE  = 2'b00;
	localparam ST_START = 2'b01;
	localparam ST_CONV1 = 2'b10;
	localparam ST_CONV2 = 2'b11;

	reg [1:0]              state_q;
	reg [1:0]              state_d;
	reg                    start_q;
	reg                    start_d;
	reg [`AHPC_DATA_W-1:0] result_q;
	reg                    done_evt;

	// R4 start on write rise; second conversion when simultaneous
	// A new write aborts any running conversion: the latest request wins
	always @* begin
		state_d  = state_q;
		start_d  = 1'b0;
		done_evt = 1'b0;
		case (state_q)
			ST_IDLE: begin
				state_d = ST_IDLE;
			end
			ST_START: begin
				state_d = ST_CONV1;
			end
			ST_CONV1: begin
				if (conv_done_in) begin
					if (ctrl_q[`AHPC_SIMUL_BIT]) begin
						state_d = ST_CONV2;
						start_d = 1'b1;
					end else begin
						state_d  = ST_IDLE;
						done_evt = 1'b1;
					end
				end
			end
			ST_CONV2: begin
				if (conv_done_in && !start_q) begin
					state_d  = ST_IDLE;
					done_evt = 1'b1;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (wr_rise) begin
			state_d = ST_START;
			start_d = 1'b1;
		end
	end

	always @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_q <= ST_IDLE;
			start_q <= 1'b0;
		end else begin
			state_q <= state_d;
			start_q <= start_d;
		end
	end

	assign conv_start_out = start_q;

	// Result held for the host once a conversion reports done
	always @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in)
			result_q <= `AHPC_CTRL_RESET;
		else if (conv_done_in)
			result_q <= conv_result_in;
	end

	// ---------------------------------------------------------------
	// Status output
	// ---------------------------------------------------------------
	reg  pend_q;
	reg  status_n_q;
	wire busy_w;
	wire mode_w;

	assign busy_w = (state_q != ST_IDLE) | wr_rise;
	// Mode of the word being written applies from the write itself,
	// so a mode change never shows one cycle of the old behaviour
	assign mode_w = wr_rise ? data_s[`AHPC_STATUS_MODE] : ctrl_q[`AHPC_STATUS_MODE];

	// R7 set on completion; R8 clear on strobe fall, set wins
	// Only interrupt mode records completions, so no stale flag survives a mode change
	always @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in)
			pend_q <= 1'b0;
		else if (done_evt & ctrl_q[`AHPC_STATUS_MODE])
			pend_q <= 1'b1;
		else if (wr_fall | rd_fall)
			pend_q <= 1'b0;
	end

	// R5 mode select; R6 busy low while converting
	always @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in)
			status_n_q <= 1'b1;
		else if (mode_w)
			status_n_q <= ~pend_q;
		else
			status_n_q <= ~busy_w;
	end

	assign status_n_out = status_n_q;

	// ---------------------------------------------------------------
	// Data bus drive
	// ---------------------------------------------------------------
	// R9 drive on selected read; R12 off otherwise (R2 direction)
	// Driven from synchronised levels and registered once more, so release lags the strobe by the sync depth plus one cycle
	always @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in)
			data_q <= 1'b0;
		else
			data_q <= sel_w & ~rd_n_s;
	end

	assign host_data_bus_oe_out = data_q;
	assign host_data_bus_out    = result_q;
endmodule // ahpc_port_ctrl

// file: dv/ahpc_chk_asserts.sv
// Port checker for the converter host port control block
module ahpc_chk (
	// Clock and reset
	input wire       sys_clk_in,
	input wire       reset_in,
	// Host pins
	input wire       chip_sel_n_in,
	input wire       write_n_in,
	input wire       read_n_in,
	// Converter core
	input wire       conv_done_in,
	input wire       conv_start_out,
	input wire [2:0] channel_address_field_out,
	input wire       simul_sample_out,
	input wire [9:0] ctrl_word_out,
	// Bus and status
	input wire       host_data_bus_oe_out,
	input wire       status_n_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	property p_start; conv_start_out |=> !conv_start_out; endproperty
	a_start: assert property (p_start) else $error("start held");
	// control moves only on a write
	property p_ctrl; !$stable(ctrl_word_out) |-> conv_start_out; endproperty
	a_ctrl: assert property (p_ctrl) else $error("stray control change");
	property p_fld; channel_address_field_out == ctrl_word_out[2:0]
		&& simul_sample_out == ctrl_word_out[6]; endproperty
	a_fld: assert property (p_fld) else $error("field mismatch");
	property p_off; (chip_sel_n_in || read_n_in) [*4] |-> !host_data_bus_oe_out; endproperty
	a_off: assert property (p_off) else $error("bus driven idle");
	property p_on; (!chip_sel_n_in && !read_n_in) [*4] |-> host_data_bus_oe_out; endproperty
	a_on: assert property (p_on) else $error("read not driven");
	property p_bsy; !ctrl_word_out[9] && conv_start_out |-> !status_n_out; endproperty
	a_bsy: assert property (p_bsy) else $error("busy not low");
	// busy ends only after a done
	property p_bend; !ctrl_word_out[9] && $rose(status_n_out) |->
		$past(conv_done_in) || $past(conv_done_in, 2) || $past(conv_done_in, 3); endproperty
	a_bend: assert property (p_bend) else $error("busy ended early");
	// interrupt set by a done, then held
	property p_iset; ctrl_word_out[9] && $fell(status_n_out) |->
		$past(conv_done_in, 2) || $past(conv_done_in, 3) || $past(conv_done_in, 4); endproperty
	a_iset: assert property (p_iset) else $error("interrupt without done");
	property p_ihold; (ctrl_word_out[9] && write_n_in && read_n_in) [*8] |->
		!$rose(status_n_out); endproperty
	a_ihold: assert property (p_ihold) else $error("interrupt dropped");
	property p_iclr; ctrl_word_out[9] && !status_n_out && !chip_sel_n_in
		&& $fell(read_n_in) |-> ##[2:8] status_n_out; endproperty
	a_iclr: assert property (p_iclr) else $error("interrupt not cleared");
endmodule // ahpc_chk

bind ahpc_port_ctrl ahpc_chk ahpc_chk_i (.sys_clk_in, .reset_in, .chip_sel_n_in,
	.write_n_in, .read_n_in, .conv_done_in, .conv_start_out, .channel_address_field_out,
	.simul_sample_out, .ctrl_word_out, .host_data_bus_oe_out, .status_n_out);

// file: dv/ahpc_host.sv
// Host processor model driving the converter's parallel port
module ahpc_host (
	// Clock
	input  wire       sys_clk_in,
	// Device side of the bus
	input  wire [9:0] dev_data_in,
	input  wire       dev_oe_in,
	// Host pins
	output reg        cs_n_out = 1'h1,
	output reg        wr_n_out = 1'h1,
	output reg        rd_n_out = 1'h1,
	output wire [9:0] bus_out
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [9:0] wd_q = 10'h000;
	reg       drv_q = 1'h0;
	reg       idle_q = 1'h0;
	// Undriven bus toggles so stale data never passes
	assign bus_out = dev_oe_in ? dev_data_in : (drv_q ? wd_q : {10{idle_q}});
	always @(posedge sys_clk_in) idle_q <= ~idle_q;
	// write, data held around the rise
	task wr(input [9:0] w, input sel);
		@(negedge sys_clk_in);
		cs_n_out = !sel;
		wr_n_out = 1'h0;
		drv_q = 1'h1;
		wd_q = w;
		repeat (4) @(negedge sys_clk_in);
		wr_n_out = 1'h1;
		repeat (4) @(negedge sys_clk_in);
		cs_n_out = 1'h1;
		drv_q = 1'h0;
	endtask
	// read, waits for drivers with a bound
	task rd(output [9:0] r);
		integer k;
		@(negedge sys_clk_in);
		cs_n_out = 1'h0;
		rd_n_out = 1'h0;
		for (k = 0; k < 10 && !dev_oe_in; k = k + 1) @(negedge sys_clk_in);
		r = bus_out;
		@(negedge sys_clk_in);
		rd_n_out = 1'h1;
		cs_n_out = 1'h1;
	endtask
endmodule // ahpc_host

// file: dv/ahpc_port_ctrl_tb_top.sv
// Testbench for the converter host port control block
`include "ahpc_map.vh"
module ahpc_port_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	reg        sys_clk_in = 1'h0;
	reg        reset_in = 1'h1;
	reg        conv_done_in = 1'h0;
	reg  [9:0] conv_result_in = 10'h000;
	reg  [9:0] exp_res, w, r;
	reg  [9:0] starts = 10'h000, s0;
	wire [9:0] bus, dout, ctrl;
	wire [2:0] chan;
	wire       cs_n, wr_n, rd_n, oe, start, simul, status_n;
	integer    seed = 32'h65C7;
	integer    err_count = 0, compares = 0, cnt = 0, i;
	initial forever #2.5 sys_clk_in = ~sys_clk_in;
	ahpc_port_ctrl ahpc_port_ctrl_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
		.chip_sel_n_in(cs_n), .write_n_in(wr_n), .read_n_in(rd_n),
		.host_data_bus_in(bus), .host_data_bus_out(dout), .host_data_bus_oe_out(oe),
		.conv_done_in(conv_done_in), .conv_result_in(conv_result_in), .conv_start_out(start),
		.channel_address_field_out(chan), .simul_sample_out(simul), .ctrl_word_out(ctrl),
		.status_n_out(status_n));
	ahpc_host ahpc_host_i (.sys_clk_in(sys_clk_in), .dev_data_in(dout), .dev_oe_in(oe),
		.cs_n_out(cs_n), .wr_n_out(wr_n), .rd_n_out(rd_n), .bus_out(bus));
	// Converter core stand-in: fixed latency, random result, restarts on start
	always @(negedge sys_clk_in) begin
		conv_done_in <= 1'h0;
		if (cnt == 1) begin
			exp_res = $random(seed);
			conv_done_in <= 1'h1;
			conv_result_in <= exp_res;
		end
		cnt <= start ? 6 : (cnt != 0 ? cnt - 1 : 0);
		if (start === 1'h1) starts <= starts + 10'h001;
	end
	function [3:0] f_fields(input [9:0] x);
		f_fields = {x[`AHPC_SIMUL_BIT], x[`AHPC_CHAN_MSB:`AHPC_CHAN_LSB]};
	endfunction
	task chk1(input got, input exp);
		compares = compares + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("Error at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask
	task chk10(input [9:0] got, input [9:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("Error at %0t: word %h expected %h", $time, got, exp);
		end
	endtask
	// Bounded wait for a status level
	task wt(input v);
		integer k;
		for (k = 0; k < 80 && status_n !== v; k = k + 1) @(negedge sys_clk_in);
	endtask
	task tally_and_finish;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Watchdog, well beyond the expected run
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		err_count = err_count + 1;
		tally_and_finish;
	end
	initial begin
		repeat (8) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
		reset_in = 1'h0;
		chk10(ctrl, 10'h000);
		chk1(status_n, 1'h1);
		for (i = 0; i < 16; i = i + 1) begin
			w = $random(seed);
			// First four force both modes, single and pair
			if (i < 4) w[9] = i[0];
			if (i < 4) w[6] = i[1];
			s0 = starts;
			ahpc_host_i.wr(w, 1'h1);
			chk10(ctrl, w);
			chk10({6'h00, simul, chan}, {6'h00, f_fields(w)});
			chk1(status_n, w[9]);
			wt(!w[9]);
			chk1(status_n, !w[9]);
			ahpc_host_i.wr(~w, 1'h0);
			chk10(ctrl, w);
			chk10(starts - s0, w[`AHPC_SIMUL_BIT] ? 10'h002 : 10'h001);
			ahpc_host_i.rd(r);
			chk10(r, exp_res);
			repeat (8) @(negedge sys_clk_in);
			chk1(status_n, 1'h1);
			$display("test %0d done", i);
		end
		tally_and_finish;
	end
endmodule // ahpc_port_ctrl_tb_top
